// [common/sdram_pin_pkg.sv]
// Constants shared by the DRAM pin-function front end
`default_nettype none
package sdram_pin_pkg;
  // Address bus width and special bit positions
  localparam int ADDR_W        = 16;
  localparam int AUTO_PRE_BIT  = 10;
  localparam int BURST_SEL_BIT = 12;
  localparam int BANK_W        = 2;
  localparam int LANE_W        = 8;
  // Mode register op-code bit positions
  localparam int MR4_VREF_BIT  = 4;
  localparam int MR5_PAR_LO    = 0;
  localparam int MR5_PAR_HI    = 2;
  localparam int MRS_SEL_W     = 3;
  localparam logic [2:0] MR_SEL_FOUR = 3'h4;
  localparam logic [2:0] MR_SEL_FIVE = 3'h5;
  // Burst lengths in beats
  localparam int BURST_FULL    = 8;
  localparam int BURST_CHOP    = 4;
  localparam int CRC_BEATS     = 2;
  // Alert pulse times
  localparam int CLK_MHZ       = 200;
  localparam int CRC_ALERT_NS  = 60;
  localparam int PAR_ALERT_NS  = 600;
  localparam int CRC_ALERT_CYC = (CRC_ALERT_NS * CLK_MHZ) / 1000;
  localparam int PAR_ALERT_CYC = (PAR_ALERT_NS * CLK_MHZ) / 1000;
  // Reset values
  localparam logic [ADDR_W-1:0] MR_RESET = 16'h0000;
  // Decoded commands
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_ACT  = 3'h1,
    CMD_RD   = 3'h2,
    CMD_WR   = 3'h3,
    CMD_PRE  = 3'h4,
    CMD_MRS  = 3'h5
  } cmd_e;
endpackage
`default_nettype wire

// [rtl/sdram_pin_functions.sv]
// DRAM pin-function front end: command decode, parity, alert, strobes, test mode
`timescale 1ns/100ps
`default_nettype none

// Small FIFO of flip-flops with valid/ready on both sides
module beat_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // Storage
  logic [AW-1:0]    wr_ptr;           // Write index
  logic [AW-1:0]    rd_ptr;           // Read index
  logic [AW:0]      count;            // Occupancy
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // Pointers and occupancy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
      count <= (AW+1)'(count + {AW'(0), push} - {AW'(0), pop});
    end
  end

  // Data store, no reset needed on payload
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule

module sdram_pin_functions
  import sdram_pin_pkg::*;
#(
  parameter int CRC_CYC = CRC_ALERT_CYC,
  parameter int PAR_CYC = PAR_ALERT_CYC
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              reset_low,              // Device reset pin, active low
  input  wire logic              link_clk,               // Command clock pin, sampled
  input  wire logic              chip_select_low,
  input  wire logic              activate_cmd_low,
  input  wire logic              row_strobe_cmd_low,
  input  wire logic              column_strobe_cmd_low,
  input  wire logic              write_enable_cmd_low,
  input  wire logic              bank_group,
  input  wire logic [BANK_W-1:0] bank_addr,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              cmd_addr_parity_in,
  input  wire logic              connectivity_test_enable,
  input  wire logic              crc_error_in,           // Write CRC check result, pulse
  // Alert pin, open drain
  input  wire logic              alert_in,
  output logic                   alert_out,
  output logic                   alert_oe,
  // Lower lane strobe and data
  input  wire logic              lower_lane_strobe_t_in,
  input  wire logic              lower_lane_strobe_c_in,
  output logic                   lower_lane_strobe_t_out,
  output logic                   lower_lane_strobe_c_out,
  output logic                   lower_lane_strobe_oe,
  input  wire logic [LANE_W-1:0] lower_lane_data_in,
  input  wire logic              lower_write_mask_low,
  // Upper lane strobe and data
  input  wire logic              upper_lane_strobe_t_in,
  input  wire logic              upper_lane_strobe_c_in,
  output logic                   upper_lane_strobe_t_out,
  output logic                   upper_lane_strobe_c_out,
  output logic                   upper_lane_strobe_oe,
  input  wire logic [LANE_W-1:0] upper_lane_data_in,
  input  wire logic              upper_write_mask_low,
  // Read data source and outputs
  input  wire logic [2*LANE_W-1:0] rd_word,
  output logic      [LANE_W-1:0] lower_lane_data_out,
  output logic      [LANE_W-1:0] upper_lane_data_out,
  output logic      [LANE_W-1:0] data_oe,
  // Decoded command results
  output logic                   cmd_valid,
  output cmd_e                   cmd_kind,
  output logic      [ADDR_W-1:0] row_addr,
  output logic      [ADDR_W-1:0] col_addr,
  output logic                   auto_precharge_flag,
  output logic                   burst_chop_select,
  output logic                   precharge_all,
  output logic      [BANK_W-1:0] precharge_bank,
  output logic                   parity_error,
  output logic                   vref_test_mode,
  output logic                   connectivity_test_active,
  output logic                   crc_enable,
  output logic                   alert_seen_in,
  // Write beat stream out of the FIFO
  output logic                   wr_valid,
  input  wire logic              wr_ready,
  output logic      [2*LANE_W+1:0] wr_data,
  output logic                   wr_overflow
);
  // Two-stage synchronisers for every pin input except the unused complement strobes
  // Two data lanes, bank address, address and fifteen single-bit pins
  localparam int SYN_W = 2*LANE_W + BANK_W + ADDR_W + 15;
  logic [SYN_W-1:0] sync1;                  // First stage only feeds sync2
  logic [SYN_W-1:0] sync2;                  // Safe sampled pins
  logic             ck_prev;                // Previous sampled link clock
  logic [1:0]       rst_sync;               // Device reset synchroniser
  wire  [SYN_W-1:0] pins = {link_clk, chip_select_low, activate_cmd_low,
                            row_strobe_cmd_low, column_strobe_cmd_low,
                            write_enable_cmd_low, bank_group, bank_addr, addr,
                            cmd_addr_parity_in, connectivity_test_enable, alert_in,
                            lower_lane_strobe_t_in, upper_lane_strobe_t_in,
                            lower_write_mask_low, upper_write_mask_low,
                            upper_lane_data_in, lower_lane_data_in, crc_error_in};

  // Named slices of the synchronised pins
  wire              s_ck   = sync2[SYN_W-1];
  wire              s_cs   = sync2[SYN_W-2];
  wire              s_act  = sync2[SYN_W-3];
  wire              s_ras  = sync2[SYN_W-4];
  wire              s_cas  = sync2[SYN_W-5];
  wire              s_we   = sync2[SYN_W-6];
  wire              s_bg   = sync2[SYN_W-7];
  wire [BANK_W-1:0] s_ba   = sync2[SYN_W-8 -: BANK_W];
  wire [ADDR_W-1:0] s_addr = sync2[SYN_W-8-BANK_W -: ADDR_W];
  localparam int LO = 2*LANE_W - 1;       // Single pins start just above the lanes
  wire              s_par  = sync2[LO+8];
  wire              s_ten  = sync2[LO+7];
  wire              s_alrt = sync2[LO+6];
  wire              s_lower_lane_strobe = sync2[LO+5];
  wire              s_upper_lane_strobe = sync2[LO+4];
  wire              s_dml  = sync2[LO+3];
  wire              s_dmu  = sync2[LO+2];
  wire [2*LANE_W-1:0] s_dq = sync2[2*LANE_W:1];
  wire              s_crc  = sync2[0];
  wire              ck_rise = s_ck & ~ck_prev;
  wire              dev_rst = ~rst_sync[1];

  // Pin sampling
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1   <= '0;
      sync2   <= '0;
      ck_prev <= 1'b0;
    end else begin
      sync1   <= pins;
      sync2   <= sync1;
      ck_prev <= s_ck;
    end
  end

  always_ff @(posedge clk or negedge reset_low) begin
    if (!reset_low) rst_sync <= 2'h0;
    else            rst_sync <= {rst_sync[0], 1'b1};
  end

  // Command decode on a rising command clock edge
  wire  selected = ck_rise & ~s_cs;
  wire  is_act = selected & ~s_act;
  wire  is_rd  = selected & s_act & s_ras & ~s_cas & s_we;
  wire  is_wr  = selected & s_act & s_ras & ~s_cas & ~s_we;
  wire  is_pre = selected & s_act & ~s_ras & s_cas & ~s_we;
  wire  is_mrs = selected & s_act & ~s_ras & ~s_cas & ~s_we;
  cmd_e next_kind;
  assign next_kind = is_act ? CMD_ACT : is_rd ? CMD_RD : is_wr ? CMD_WR :
                     is_pre ? CMD_PRE : is_mrs ? CMD_MRS : CMD_NONE;

  // even parity over command and address
  wire  par_bad = ^{s_act, s_ras, s_cas, s_we, s_bg, s_ba, s_addr, s_par};
  wire  [MRS_SEL_W-1:0] mr_sel = {s_bg, s_ba};
  logic [ADDR_W-1:0] mr_four;                  // Stored op-code of register four
  logic [ADDR_W-1:0] mr_five;                  // Stored op-code of register five
  wire  par_on = (mr_five[MR5_PAR_HI:MR5_PAR_LO] != '0);
  wire  par_hit = selected & par_on & par_bad;
  wire  cmd_ok = (next_kind != CMD_NONE) & ~par_hit;

  // Mode registers; parity-failed commands do not update
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mr_four <= MR_RESET;
      mr_five <= MR_RESET;
    end else if (dev_rst) begin
      mr_four <= MR_RESET;
      mr_five <= MR_RESET;
    end else if (is_mrs & ~par_hit) begin
      if (mr_sel == MR_SEL_FOUR) mr_four <= s_addr;
      if (mr_sel == MR_SEL_FIVE) mr_five <= s_addr;
    end
  end

  // Registered command results
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      cmd_kind  <= CMD_NONE;
      row_addr  <= '0;
      col_addr  <= '0;
      auto_precharge_flag <= 1'b0;
      burst_chop_select   <= 1'b1;
      precharge_all       <= 1'b0;
      precharge_bank      <= '0;
    end else begin
      cmd_valid <= cmd_ok & ~dev_rst;
      if (cmd_ok) begin
        cmd_kind <= next_kind;
        // row on activate, column on access
        if (is_act) row_addr <= s_addr;
        if (is_rd | is_wr) begin
          col_addr <= s_addr;
          auto_precharge_flag <= s_addr[AUTO_PRE_BIT];
          burst_chop_select <= s_addr[BURST_SEL_BIT];
        end
        if (is_pre) begin
          precharge_all  <= s_addr[AUTO_PRE_BIT];
          precharge_bank <= s_ba;
        end
      end
    end
  end

  assign vref_test_mode = mr_four[MR4_VREF_BIT];   // reference test mode
  assign crc_enable     = mr_five[MR5_PAR_HI+1];   // CRC enable bit

  // Alert timer; parity error outranks CRC error
  logic [$clog2(PAR_CYC+1)-1:0] alert_cnt;
  logic                         alert_long;        // Parity recovery in progress
  wire  crc_hit = s_crc & ~connectivity_test_active;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_cnt    <= '0;
      alert_long   <= 1'b0;
      parity_error <= 1'b0;
    end else begin
      parity_error <= par_hit;
      if (par_hit) begin
        alert_cnt  <= ($clog2(PAR_CYC+1))'(PAR_CYC);
        alert_long <= 1'b1;
      end else if (crc_hit && alert_cnt == '0) begin
        alert_cnt <= ($clog2(PAR_CYC+1))'(CRC_CYC);
      end else if (alert_cnt != '0) begin
        alert_cnt <= alert_cnt - 1'b1;
        if (alert_cnt == 1) alert_long <= 1'b0;
      end
    end
  end

  // test enable pin enters connectivity test
  assign connectivity_test_active = s_ten & ~dev_rst;
  // alert pin becomes input during test
  assign alert_oe      = (alert_cnt != '0) & ~connectivity_test_active;
  assign alert_out     = 1'b0;
  assign alert_seen_in = connectivity_test_active & ~s_alrt;

  // Write beats: lanes paired with own strobe, masks drop lanes
  logic lower_lane_strobe_prev;
  logic upper_lane_strobe_prev;
  logic wr_active;                            // Burst window open
  logic [3:0] beat_cnt;
  wire  lower_lane_strobe_edge = s_lower_lane_strobe ^ lower_lane_strobe_prev;
  wire  upper_lane_strobe_edge = s_upper_lane_strobe ^ upper_lane_strobe_prev;
  // burst plus CRC beats when enabled
  wire  [3:0] beat_total = 4'((burst_chop_select ? BURST_FULL : BURST_CHOP)
                              + (crc_enable ? CRC_BEATS : 0));
  wire  lane_lo = wr_active & lower_lane_strobe_edge & s_dml;
  wire  lane_hi = wr_active & upper_lane_strobe_edge & s_dmu;
  wire  fifo_in_ready;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lower_lane_strobe_prev   <= 1'b0;
      upper_lane_strobe_prev   <= 1'b0;
      wr_active   <= 1'b0;
      beat_cnt    <= '0;
      wr_overflow <= 1'b0;
    end else begin
      lower_lane_strobe_prev <= s_lower_lane_strobe;
      upper_lane_strobe_prev <= s_upper_lane_strobe;
      if (cmd_valid && cmd_kind == CMD_WR) begin
        wr_active <= 1'b1;
        beat_cnt  <= '0;
      end else if (wr_active && lower_lane_strobe_edge) begin
        beat_cnt <= beat_cnt + 1'b1;
        if (beat_cnt == beat_total - 1'b1) wr_active <= 1'b0;
      end
      wr_overflow <= (lane_lo | lane_hi) & ~fifo_in_ready;
    end
  end

  beat_fifo #(.WIDTH(2*LANE_W+2), .DEPTH(16)) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (lane_lo | lane_hi),
    .in_ready  (fifo_in_ready),
    .in_data   ({lane_hi, lane_lo, s_dq}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_data)
  );

  // Read strobes: edge aligned toggling with data, true/complement pair
  logic rd_active;
  logic rd_strobe;
  logic [3:0] rd_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_active <= 1'b0;
      rd_strobe <= 1'b0;
      rd_cnt    <= '0;
      lower_lane_data_out <= '0;
      upper_lane_data_out <= '0;
    end else begin
      if (cmd_valid && cmd_kind == CMD_RD) begin
        rd_active <= 1'b1;
        rd_cnt    <= '0;
      end else if (rd_active) begin
        rd_strobe <= ~rd_strobe;
        rd_cnt    <= rd_cnt + 1'b1;
        if (rd_cnt == 4'(burst_chop_select ? BURST_FULL-1 : BURST_CHOP-1))
          rd_active <= 1'b0;
      end
      // reference level shown on data line 0 in test
      lower_lane_data_out <= vref_test_mode ? 8'h01 : rd_word[LANE_W-1:0];
      upper_lane_data_out <= rd_word[2*LANE_W-1:LANE_W];
    end
  end

  assign lower_lane_strobe_t_out = rd_strobe;
  assign lower_lane_strobe_c_out = ~rd_strobe;
  assign upper_lane_strobe_t_out = rd_strobe;
  assign upper_lane_strobe_c_out = ~rd_strobe;
  assign lower_lane_strobe_oe    = rd_active;
  assign upper_lane_strobe_oe    = rd_active;
  assign data_oe = (rd_active | vref_test_mode) ? 8'hFF : 8'h00;

  // a_ alert holds long after parity error
  a_parity_alert_long: assert property (@(posedge clk) disable iff (sys_rst)
    par_hit && !connectivity_test_active |=> alert_oe [*8])
    else $error("parity alert too short");
  a_crc_alert_on: assert property (@(posedge clk) disable iff (sys_rst)
    crc_hit && alert_cnt == '0 && !par_hit |=> alert_oe)
    else $error("crc alert missing");
  a_parity_off_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !par_on |=> !parity_error)
    else $error("parity flagged while disabled");
  a_test_alert_input: assert property (@(posedge clk) disable iff (sys_rst)
    connectivity_test_active |-> !alert_oe)
    else $error("alert driven in test mode");
  a_cs_masks_cmd: assert property (@(posedge clk) disable iff (sys_rst)
    s_cs |=> !cmd_valid)
    else $error("command taken with chip select high");
  a_auto_pre_sample: assert property (@(posedge clk) disable iff (sys_rst)
    (is_rd | is_wr) && cmd_ok |=> auto_precharge_flag == $past(s_addr[AUTO_PRE_BIT]))
    else $error("auto precharge not sampled");
  a_burst_chop_sample: assert property (@(posedge clk) disable iff (sys_rst)
    (is_rd | is_wr) && cmd_ok |=> burst_chop_select == $past(s_addr[BURST_SEL_BIT]))
    else $error("burst chop not sampled");
  a_pre_all_sample: assert property (@(posedge clk) disable iff (sys_rst)
    is_pre && cmd_ok |=> precharge_all == $past(s_addr[AUTO_PRE_BIT]))
    else $error("precharge scope wrong");
  a_strobe_pair: assert property (@(posedge clk) disable iff (sys_rst)
    lower_lane_strobe_t_out != lower_lane_strobe_c_out)
    else $error("strobe pair not complementary");
endmodule
`default_nettype wire

// [bench/host_ctrl_model.sv]
// Host controller model: command clock, command pins and write beats
`timescale 1ns/100ps
`default_nettype none
module host_ctrl_model
  import sdram_pin_pkg::*;
(
  input  wire logic              clk,
  output logic                   link_clk,
  output logic                   chip_select_low,
  output logic                   activate_cmd_low,
  output logic                   row_strobe_cmd_low,
  output logic                   column_strobe_cmd_low,
  output logic                   write_enable_cmd_low,
  output logic                   bank_group,
  output logic      [BANK_W-1:0] bank_addr,
  output logic      [ADDR_W-1:0] addr,
  output logic                   cmd_addr_parity_in,
  output logic                   strobe,
  output logic      [LANE_W-1:0] lower_lane_data_in,
  output logic      [LANE_W-1:0] upper_lane_data_in,
  output logic                   lower_write_mask_low,
  output logic                   upper_write_mask_low
);
  // Free running command clock, phase unrelated to clk
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #80 link_clk = ~link_clk;
  end
  // Idle: deselected, strobe parked low, lanes kept
  initial begin
    {chip_select_low, activate_cmd_low, row_strobe_cmd_low} = 3'h7;
    {column_strobe_cmd_low, write_enable_cmd_low} = 2'h3;
    {bank_group, bank_addr, addr, cmd_addr_parity_in} = 20'h00000;
    {strobe, upper_write_mask_low, lower_write_mask_low} = 3'h3;
    {upper_lane_data_in, lower_lane_data_in} = 16'h00FF;
  end
  // Pins set after a falling link edge, held over the next rising edge
  task automatic cmd(input cmd_e kind, input logic [2:0] sel, input logic [ADDR_W-1:0] a,
                     input logic bad_par, input logic cs_off);
    logic [3:0] code;
    case (kind)
      CMD_ACT: code = 4'h7;
      CMD_RD:  code = 4'hD;
      CMD_WR:  code = 4'hC;
      CMD_PRE: code = 4'hA;
      default: code = 4'h8;
    endcase
    @(negedge link_clk);
    @(posedge clk);
    chip_select_low <= cs_off;
    {activate_cmd_low, row_strobe_cmd_low, column_strobe_cmd_low, write_enable_cmd_low} <= code;
    {bank_group, bank_addr} <= sel;
    addr <= a;
    cmd_addr_parity_in <= ^{code, sel, a} ^ bad_par;
    @(negedge link_clk);
    @(posedge clk);
    chip_select_low <= 1'b1;
    addr <= ~a;
  endtask
  // data settles first, strobe edge three clocks later, data held six clocks more, both lanes
  task automatic beat(input logic [15:0] d, input logic [1:0] keep);
    @(posedge clk);
    {upper_lane_data_in, lower_lane_data_in} <= d;
    {upper_write_mask_low, lower_write_mask_low} <= keep;
    repeat (3) @(posedge clk);
    strobe <= ~strobe;
    repeat (6) @(posedge clk);
    {upper_lane_data_in, lower_lane_data_in} <= ~d;
  endtask
endmodule
`default_nettype wire

// [bench/sdram_pin_functions_tb_top.sv]
// Self-checking bench for the DRAM pin-function front end
`timescale 1ns/100ps
`default_nettype none
module sdram_pin_functions_tb_top
  import sdram_pin_pkg::*;
;
  localparam int CRC_T = 4;   // Shortened alert lengths keep the run brief
  localparam int PAR_T = 16;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reset_low = 1'b1;
  logic              connectivity_test_enable = 1'b0;
  logic              crc_error_in = 1'b0;
  logic              alert_drv_low = 1'b0;  // Bench side pulls alert low
  logic              wr_ready = 1'b0;
  logic [15:0]       rd_word = 16'h0000;
  logic              link_clk, chip_select_low, activate_cmd_low, row_strobe_cmd_low;
  logic              column_strobe_cmd_low, write_enable_cmd_low, bank_group, cmd_addr_parity_in;
  logic [1:0]        bank_addr, precharge_bank;
  logic [15:0]       addr, row_addr, col_addr, a;
  logic [7:0]        lower_lane_data_in, upper_lane_data_in, lo_d, up_d, d_oe;
  logic              strobe, lower_write_mask_low, upper_write_mask_low, alert_oe, alert_out;
  logic              lo_t, lo_c, lo_oe, up_t, up_c, up_oe, cmd_valid, auto_precharge_flag;
  logic              burst_chop_select, precharge_all, parity_error, vref_test_mode;
  logic              connectivity_test_active, crc_enable, alert_seen_in, wr_valid, wr_overflow;
  cmd_e              cmd_kind;
  logic [17:0]       wr_data, e;
  logic [17:0]       exp_q[$];             // Beats the model expects to pop
  logic [17:0]       got_q[$];             // Beats seen leaving the buffer
  logic [31:0]       seed = 32'h00015B14;
  int                n_mismatch = 0, checked = 0, n_cmd = 0, n_par = 0, n_alert = 0, n_ovf = 0;
  int                i, base, pc;
  // Open drain alert wire with pull-up
  wire logic         alert_in = ~(alert_oe | alert_drv_low);
  wire logic         strobe_c = ~strobe;

  always #2.5 clk = ~clk;

  host_ctrl_model i_host (.clk, .link_clk, .chip_select_low, .activate_cmd_low,
    .row_strobe_cmd_low, .column_strobe_cmd_low, .write_enable_cmd_low, .bank_group,
    .bank_addr, .addr, .cmd_addr_parity_in, .strobe, .lower_lane_data_in,
    .upper_lane_data_in, .lower_write_mask_low, .upper_write_mask_low);

  sdram_pin_functions #(.CRC_CYC(CRC_T), .PAR_CYC(PAR_T)) i_dut (.clk, .sys_rst, .reset_low,
    .link_clk, .chip_select_low, .activate_cmd_low, .row_strobe_cmd_low, .column_strobe_cmd_low,
    .write_enable_cmd_low, .bank_group, .bank_addr, .addr, .cmd_addr_parity_in,
    .connectivity_test_enable, .crc_error_in, .alert_in, .alert_out, .alert_oe,
    .lower_lane_strobe_t_in(strobe), .lower_lane_strobe_c_in(strobe_c),
    .lower_lane_strobe_t_out(lo_t), .lower_lane_strobe_c_out(lo_c),
    .lower_lane_strobe_oe(lo_oe), .lower_lane_data_in, .lower_write_mask_low,
    .upper_lane_strobe_t_in(strobe), .upper_lane_strobe_c_in(strobe_c),
    .upper_lane_strobe_t_out(up_t), .upper_lane_strobe_c_out(up_c),
    .upper_lane_strobe_oe(up_oe), .upper_lane_data_in, .upper_write_mask_low, .rd_word,
    .lower_lane_data_out(lo_d), .upper_lane_data_out(up_d), .data_oe(d_oe),
    .cmd_valid, .cmd_kind,
    .row_addr, .col_addr, .auto_precharge_flag, .burst_chop_select, .precharge_all,
    .precharge_bank, .parity_error, .vref_test_mode, .connectivity_test_active, .crc_enable,
    .alert_seen_in, .wr_valid, .wr_ready, .wr_data, .wr_overflow);

  // Xorshift source for addresses, data and stall pattern
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Keep only lanes marked valid, valid bits always compared
  function automatic logic [17:0] lanes(input logic [17:0] v);
    return v & {2'h3, {8{v[17]}}, {8{v[16]}}};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One command, then count how many the block accepted
  task automatic issue(input cmd_e k, input logic [2:0] sel, input logic [15:0] av,
                       input logic bad, input logic off, input int n);
    int c0;
    c0 = n_cmd;
    i_host.cmd(k, sel, av, bad, off);
    repeat (8) @(posedge clk);
    check(n_cmd - c0, n);
  endtask

  // Event counters, popped beats and strobe pair checks
  always @(posedge clk) begin
    rd_word <= rd_word + 16'h3B1D;
    if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
    if (parity_error === 1'b1) n_par <= n_par + 1;
    if (alert_oe === 1'b1) begin
      n_alert <= n_alert + 1;
      check(alert_out, 0);
    end
    if (wr_overflow === 1'b1) n_ovf <= n_ovf + 1;
    if (wr_valid === 1'b1 && wr_ready) got_q.push_back(wr_data);
    if (lo_oe === 1'b1) begin
      check(lo_c ^ lo_t, 32'h1);
      check({up_oe, up_c ^ up_t}, 2'h3);
      // Read data is the source word taken one clock earlier
      check({d_oe, up_d, lo_d}, {8'hFF, 16'(rd_word - 16'h3B1D)});
    end
  end

  // Watchdog: about forty times the expected run length
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    check({alert_oe, burst_chop_select, cmd_valid, wr_valid, lo_c}, 5'h09);
    a = 16'(xs());
    issue(CMD_ACT, 3'h1, a, 1'b0, 1'b0, 1);
    check({cmd_kind, row_addr}, {CMD_ACT, a});
    issue(CMD_ACT, 3'h1, ~a, 1'b0, 1'b1, 0);
    check(row_addr, a);
    // Reads over every auto-precharge and chop combination
    for (i = 0; i < 4; i++) begin
      a = 16'(xs());
      a[10] = i[0];
      a[12] = i[1];
      issue(CMD_RD, 3'h2, a, 1'b0, 1'b0, 1);
      check({cmd_kind, col_addr[9:0]}, {CMD_RD, a[9:0]});
      check({auto_precharge_flag, burst_chop_select}, {a[10], a[12]});
    end
    for (i = 0; i < 2; i++) begin
      issue(CMD_PRE, 3'h2, {5'h00, i[0], 10'h155}, 1'b0, 1'b0, 1);
      check({precharge_all, precharge_bank}, {i[0], 2'h2});
    end
    issue(CMD_MRS, MR_SEL_FOUR, 16'h0010, 1'b0, 1'b0, 1);
    check(vref_test_mode, 1);
    check({d_oe, lo_d}, 16'hFF01);
    reset_low <= 1'b0;
    repeat (3) @(posedge clk);
    check(vref_test_mode, 0);
    reset_low <= 1'b1;
    repeat (6) @(posedge clk);
    // Parity on: bad parity refused with long alert
    issue(CMD_MRS, MR_SEL_FIVE, 16'h0001, 1'b0, 1'b0, 1);
    base = n_alert;
    pc = n_par;
    issue(CMD_ACT, 3'h1, 16'h0F0F, 1'b1, 1'b0, 0);
    repeat (PAR_T + 20) @(posedge clk);
    check(n_par - pc, 1);
    check(n_alert - base, PAR_T);
    issue(CMD_ACT, 3'h1, 16'h0F0F, 1'b0, 1'b0, 1);
    // Parity off, CRC on: parity ignored, CRC error gives short alert
    issue(CMD_MRS, MR_SEL_FIVE, 16'h0008, 1'b0, 1'b0, 1);
    check(crc_enable, 1);
    base = n_alert;
    pc = n_par;
    issue(CMD_ACT, 3'h1, 16'h00F0, 1'b1, 1'b0, 1);
    check(n_par - pc + n_alert - base, 0);
    crc_error_in <= 1'b1;
    @(posedge clk);
    crc_error_in <= 1'b0;
    repeat (CRC_T + 10) @(posedge clk);
    check(n_alert - base, CRC_T);
    issue(CMD_MRS, MR_SEL_FIVE, 16'h0000, 1'b0, 1'b0, 1);
    // Chop, full, chop fill sixteen places; last full burst overflows
    for (i = 0; i < 4; i++) begin
      issue(CMD_WR, 3'h2, {3'h0, i[0], 1'b0, ~i[0], 10'h020}, 1'b0, 1'b0, 1);
      check({cmd_kind, auto_precharge_flag, burst_chop_select}, {CMD_WR, ~i[0], i[0]});
      for (int b = 0; b < (i[0] ? BURST_FULL : BURST_CHOP); b++) begin
        e = {2'(b % 3 + 1), 16'(xs())};
        i_host.beat(e[15:0], e[17:16]);
        if (i < 3) exp_q.push_back(e);
      end
    end
    repeat (8) @(posedge clk);
    check(n_ovf != 0, 1);
    // Drain with the far side stalling at random
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      wr_ready <= 1'(xs());
    end
    @(posedge clk);
    wr_ready <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'(got_q.size()), wr_valid}, {31'd16, 1'b0});
    foreach (exp_q[k]) check(lanes(got_q[k]), lanes(exp_q[k]));
    // CRC on: a chopped write takes two extra beats, one more strobe edge is ignored
    wr_ready <= 1'b1;
    issue(CMD_MRS, MR_SEL_FIVE, 16'h0008, 1'b0, 1'b0, 1);
    issue(CMD_WR, 3'h2, 16'h0000, 1'b0, 1'b0, 1);
    for (i = 0; i < BURST_CHOP + CRC_BEATS + 1; i++) i_host.beat(16'(xs()), 2'h1);
    repeat (8) @(posedge clk);
    check(got_q.size(), 16 + BURST_CHOP + CRC_BEATS);
    connectivity_test_enable <= 1'b1;
    repeat (4) @(posedge clk);
    check(connectivity_test_active, 1);
    base = n_alert;
    alert_drv_low <= 1'b1;
    crc_error_in <= 1'b1;
    @(posedge clk);
    crc_error_in <= 1'b0;
    repeat (CRC_T + 4) @(posedge clk);
    check(alert_seen_in, 1);
    check(n_alert - base, 0);
    test_done();
  end
endmodule
`default_nettype wire
